// *** design/fsbp_regs.svh ***
// Offsets, field positions, reset values and limits of the status and portal registers.
// Assumes a 7-bit MPU address: byte address in byte mode, word address in word mode.
`ifndef FSBP_REGS_SVH
`define FSBP_REGS_SVH
`define FSBP_STATUS_BYTE_ADDR   7'h1C
`define FSBP_STATUS_WORD_ADDR   7'h0E
`define FSBP_PORTAL_BYTE_FIRST  7'h40
`define FSBP_PORTAL_BYTE_LAST   7'h5F
`define FSBP_PORTAL_WORD_FIRST  7'h20
`define FSBP_PORTAL_WORD_LAST   7'h2F
`define FSBP_BIT_MASTER_FOUND   0
`define FSBP_BIT_PART_FOUND     1
`define FSBP_BIT_MASTER_T12     2
`define FSBP_BIT_PART_T12       3
`define FSBP_BIT_MASTER_T16     4
`define FSBP_BIT_PART_T16       5
`define FSBP_BIT_COMPUTED_T12   6
`define FSBP_BIT_COMPUTED_T16   7
`define FSBP_STATUS_RESET       16'h0000
`define FSBP_DATA_RESET         16'h0000
`define FSBP_TYPE12_LIMIT       32'h0000_0FF5
`define FSBP_TYPE16_LIMIT       32'h0000_FFF5
`define FSBP_FIFO_DEPTH         32
`define FSBP_WORD_WIDTH         16
`endif

// *** design/fsbp_pkg.sv ***
// Types shared by the filesystem status and buffer portal logic.
// Assumes the constants of fsbp_regs.svh.
package fsbp_pkg;
  typedef logic [15:0] fsbp_word_t;
  typedef logic [6:0]  fsbp_addr_t;
  typedef enum logic [1:0] {
    FSBP_LANE_LOW  = 2'b01,
    FSBP_LANE_HIGH = 2'b10
  } fsbp_lane_e;
endpackage

// *** design/fsbp_portal.sv ***
// Filesystem status register and data buffer portal of the MPU port, with its two FIFOs.
// Assumes MPU strobes synchronous to core_clk_i and a parser that holds its findings as levels.
// How it works
// - Status shows current valid partition findings
// - Status at byte 1Ch-1Dh, word 0Eh
// - Bit 0 set for valid master record
// - Bit 1 set for valid partition record
// - Bit 2 mirrors master record type12 flag
// - Bit 3 mirrors partition record type12 flag
// - Bit 4 mirrors master record type16 flag
// - Bit 5 mirrors partition record type16 flag
// - Bit 6 set when clusters below 4085
// - Bit 7 set for clusters 4085 to 65524
// - Portal at byte 40h-5Fh, word 20h-2Fh
// - Portal moves data through internal buffer
// - Portal readable at direction 0, writable at 1
// - Portal low byte usable in both modes
`timescale 1ns/100ps
`include "fsbp_regs.svh"

module fsbp_fifo #(
  parameter int WIDTH = `FSBP_WORD_WIDTH,
  parameter int DEPTH = `FSBP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  // Filling side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Draining side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic [AW-1:0]    next_rd_ptr;
  logic             push;
  logic             pop;

  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign next_rd_ptr = rd_ptr + AW'(pop);

  // Head registered; bypass when the pushed word becomes the head
  always_ff @(posedge core_clk_i) begin
    if (push && wr_ptr == next_rd_ptr) begin
      out_data_o <= in_data_i;
    end else begin
      out_data_o <= mem[next_rd_ptr];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Flags are flops so both sides see clean levels
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      count       <= next_count;
      in_ready_o  <= next_count != (AW+1)'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end
endmodule // fsbp_fifo

module fsbp_portal
  import fsbp_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // MPU bus
  input  wire fsbp_addr_t  mpu_addr_i,
  input  wire logic        mpu_chip_en_n_i,
  input  wire logic        mpu_read_en_n_i,
  input  wire logic        mpu_write_en_n_i,
  input  wire fsbp_word_t  mpu_data_i,
  output fsbp_word_t       mpu_data_o,
  output logic             mpu_data_oe_o,
  // Bus mode and buffer direction
  input  wire logic        word_mode_i,
  input  wire logic        buffer_direction_i,
  output logic             buffer_ready_o,
  // Partition parser findings
  input  wire logic        master_record_found_i,
  input  wire logic        partition_record_found_i,
  input  wire logic        master_record_type12_i,
  input  wire logic        partition_record_type12_i,
  input  wire logic        master_record_type16_i,
  input  wire logic        partition_record_type16_i,
  input  wire logic [31:0] cluster_count_i,
  // Card side stream into the portal
  input  wire logic        card_rx_valid_i,
  input  wire fsbp_word_t  card_rx_data_i,
  output logic             card_rx_ready_o,
  // Card side stream out of the portal
  output logic             card_tx_valid_o,
  output fsbp_word_t       card_tx_data_o,
  input  wire logic        card_tx_ready_i
);

  function automatic logic status_hit(input fsbp_addr_t addr, input logic word_mode);
    if (word_mode) begin
      status_hit = addr == `FSBP_STATUS_WORD_ADDR;
    end else begin
      status_hit = addr[6:1] == 6'(`FSBP_STATUS_BYTE_ADDR >> 1);
    end
  endfunction

  function automatic logic portal_hit(input fsbp_addr_t addr, input logic word_mode);
    if (word_mode) begin
      portal_hit = addr >= `FSBP_PORTAL_WORD_FIRST && addr <= `FSBP_PORTAL_WORD_LAST;
    end else begin
      portal_hit = addr >= `FSBP_PORTAL_BYTE_FIRST && addr <= `FSBP_PORTAL_BYTE_LAST;
    end
  endfunction

  fsbp_word_t filesystem_status;
  fsbp_word_t next_status;
  fsbp_word_t next_rdata;
  fsbp_word_t low_hold;
  fsbp_word_t host_push_data;
  fsbp_word_t rx_head;
  fsbp_lane_e lane;
  logic       rd_act;
  logic       wr_act;
  logic       rd_act_q;
  logic       wr_act_q;
  logic       rd_take;
  logic       wr_take;
  logic       is_status;
  logic       is_portal;
  logic       host_push_valid;
  logic       host_pop;
  logic       tx_in_ready;
  logic       rx_out_valid;

  assign rd_act    = ~mpu_chip_en_n_i & ~mpu_read_en_n_i;
  assign wr_act    = ~mpu_chip_en_n_i & ~mpu_write_en_n_i;
  assign rd_take   = rd_act & ~rd_act_q;
  assign wr_take   = wr_act & ~wr_act_q;
  assign is_status = status_hit(mpu_addr_i, word_mode_i);
  assign is_portal = portal_hit(mpu_addr_i, word_mode_i);
  assign lane      = (!word_mode_i && mpu_addr_i[0]) ? FSBP_LANE_HIGH : FSBP_LANE_LOW;

  // One access per strobe assertion
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  always_comb begin
    next_status = `FSBP_STATUS_RESET;
    next_status[`FSBP_BIT_MASTER_FOUND] = master_record_found_i;
    next_status[`FSBP_BIT_PART_FOUND]   = partition_record_found_i;
    next_status[`FSBP_BIT_MASTER_T12]   = master_record_type12_i;
    next_status[`FSBP_BIT_PART_T12]     = partition_record_type12_i;
    next_status[`FSBP_BIT_MASTER_T16]   = master_record_type16_i;
    next_status[`FSBP_BIT_PART_T16]     = partition_record_type16_i;
    next_status[`FSBP_BIT_COMPUTED_T12] = cluster_count_i < `FSBP_TYPE12_LIMIT;
    // computed type16, exact 4085 counts here
    next_status[`FSBP_BIT_COMPUTED_T16] = cluster_count_i >= `FSBP_TYPE12_LIMIT &&
                                          cluster_count_i <  `FSBP_TYPE16_LIMIT;
  end

  // upper byte stays zero, no write path
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      filesystem_status <= `FSBP_STATUS_RESET;
    end else begin
      filesystem_status <= next_status;
    end
  end

  // writes only when direction is 1
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      low_hold <= `FSBP_DATA_RESET;
    end else if (wr_take && is_portal && buffer_direction_i && lane == FSBP_LANE_LOW) begin
      low_hold <= mpu_data_i;
    end
  end

  always_comb begin
    host_push_valid = 1'b0;
    host_push_data  = mpu_data_i;
    if (wr_take && is_portal && buffer_direction_i) begin
      // low byte first in byte mode
      if (word_mode_i) begin
        host_push_valid = 1'b1;
      end else if (lane == FSBP_LANE_HIGH) begin
        host_push_valid = 1'b1;
        host_push_data  = {mpu_data_i[7:0], low_hold[7:0]};
      end
    end
  end

  // reads only when direction is 0
  assign host_pop = rd_take && is_portal && !buffer_direction_i && rx_out_valid &&
                    (word_mode_i || lane == FSBP_LANE_HIGH);

  always_comb begin
    next_rdata = `FSBP_DATA_RESET;
    if (is_status) begin
      next_rdata = (lane == FSBP_LANE_HIGH) ? {8'h00, filesystem_status[15:8]}
                                            : filesystem_status;
    end else if (is_portal && !buffer_direction_i && rx_out_valid) begin
      if (word_mode_i) begin
        next_rdata = rx_head;
      end else if (lane == FSBP_LANE_HIGH) begin
        next_rdata = {8'h00, rx_head[15:8]};
      end else begin
        next_rdata = {8'h00, rx_head[7:0]};
      end
    end
  end

  // Read data captured once per strobe so a held strobe cannot pop twice
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mpu_data_o <= `FSBP_DATA_RESET;
    end else if (rd_take) begin
      mpu_data_o <= next_rdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mpu_data_oe_o  <= 1'b0;
      buffer_ready_o <= 1'b0;
    end else begin
      mpu_data_oe_o  <= rd_act;
      buffer_ready_o <= buffer_direction_i ? tx_in_ready : rx_out_valid;
    end
  end

  fsbp_fifo #(
    .WIDTH (`FSBP_WORD_WIDTH),
    .DEPTH (`FSBP_FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (host_push_valid),
    .in_data_i   (host_push_data),
    .in_ready_o  (tx_in_ready),
    .out_valid_o (card_tx_valid_o),
    .out_data_o  (card_tx_data_o),
    .out_ready_i (card_tx_ready_i)
  );

  fsbp_fifo #(
    .WIDTH (`FSBP_WORD_WIDTH),
    .DEPTH (`FSBP_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (card_rx_valid_i),
    .in_data_i   (card_rx_data_i),
    .in_ready_o  (card_rx_ready_o),
    .out_valid_o (rx_out_valid),
    .out_data_o  (rx_head),
    .out_ready_i (host_pop)
  );
endmodule // fsbp_portal

// *** testbench/fsbp_card_model.sv ***
// Card-side stream partner: numbered word source and stallable sink.
// Assumes valid/ready transfers on the rising core clock edge.
`timescale 1ns/100ps
module fsbp_card_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // Bench controls
  input  wire logic [7:0]  src_n_i,
  input  wire logic        sink_en_i,
  // Stream into the portal
  output logic             rx_valid_o,
  output logic      [15:0] rx_data_o,
  input  wire logic        rx_ready_i,
  // Stream out of the portal
  input  wire logic        tx_valid_i,
  input  wire logic [15:0] tx_data_i,
  output logic             tx_ready_o,
  output logic      [15:0] last_tx_o,
  output logic      [7:0]  n_tx_o
);
  logic [7:0] sent;
  assign rx_valid_o = sent < src_n_i;
  // Idle data inverted so a stale word never looks valid
  assign rx_data_o = rx_valid_o ? 16'hA000 + sent : ~(16'hA000 + sent);
  assign tx_ready_o = sink_en_i;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) sent <= 8'h00;
    else if (rx_valid_o && rx_ready_i) sent <= sent + 8'h01;
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) n_tx_o <= 8'h00;
    else if (tx_valid_i && tx_ready_o) n_tx_o <= n_tx_o + 8'h01;
  end
  always_ff @(posedge core_clk_i) begin
    if (tx_valid_i && tx_ready_o) last_tx_o <= tx_data_i;
  end
endmodule // fsbp_card_model

// *** testbench/fsbp_portal_properties.sv ***
// Port-level checks of fsbp_portal.
// Assumes binding to fsbp_portal, one core clock, synchronous reset.
`timescale 1ns/100ps
`include "fsbp_regs.svh"
module fsbp_portal_properties
  import fsbp_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  // MPU bus
  input wire fsbp_addr_t  mpu_addr_i,
  input wire logic        mpu_chip_en_n_i,
  input wire logic        mpu_read_en_n_i,
  input wire logic        mpu_write_en_n_i,
  input wire fsbp_word_t  mpu_data_i,
  input wire fsbp_word_t  mpu_data_o,
  input wire logic        mpu_data_oe_o,
  input wire logic        word_mode_i,
  input wire logic        buffer_direction_i,
  // Parser findings
  input wire logic        master_record_found_i,
  input wire logic        partition_record_found_i,
  input wire logic        master_record_type12_i,
  input wire logic        partition_record_type12_i,
  input wire logic        master_record_type16_i,
  input wire logic        partition_record_type16_i,
  input wire logic [31:0] cluster_count_i,
  // Card stream out
  input wire logic        card_tx_valid_o,
  input wire fsbp_word_t  card_tx_data_o,
  input wire logic        card_tx_ready_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic       rd, wr, is_port, is_stat;
  fsbp_word_t st;
  assign rd = !mpu_chip_en_n_i && !mpu_read_en_n_i;
  assign wr = !mpu_chip_en_n_i && !mpu_write_en_n_i;
  assign st = {8'h00, cluster_count_i >= 32'h0FF5 && cluster_count_i < 32'hFFF5,
    cluster_count_i < 32'h0FF5, partition_record_type16_i, master_record_type16_i,
    partition_record_type12_i, master_record_type12_i, partition_record_found_i,
    master_record_found_i};
  assign is_port = word_mode_i ? mpu_addr_i inside {[7'h20:7'h2F]}
                               : mpu_addr_i inside {[7'h40:7'h5F]};
  assign is_stat = word_mode_i ? mpu_addr_i == 7'h0E : mpu_addr_i inside {7'h1C, 7'h1D};
  sequence s_rd_take; rd && !$past(rd); endsequence
  sequence s_wr_take; wr && !$past(wr); endsequence
  property p_reset;
    @(posedge core_clk_i) disable iff (1'b0)
      reset_i |=> !mpu_data_oe_o && mpu_data_o == 16'h0000 && !card_tx_valid_o;
  endproperty
  property p_oe; 1'b1 |=> mpu_data_oe_o == $past(rd); endproperty
  property p_stat_word;
    s_rd_take ##0 (is_stat && !(!word_mode_i && mpu_addr_i[0]) && st == $past(st))
      |=> mpu_data_o == $past(st);
  endproperty
  property p_stat_hi;
    s_rd_take ##0 (!word_mode_i && mpu_addr_i == 7'h1D) |=> mpu_data_o == 16'h0000;
  endproperty
  property p_unmapped;
    s_rd_take ##0 (!is_port && !is_stat) |=> mpu_data_o == 16'h0000;
  endproperty
  property p_dir_rd;
    s_rd_take ##0 (is_port && buffer_direction_i) |=> mpu_data_o == 16'h0000;
  endproperty
  property p_tx_push;
    s_wr_take ##0 (is_port && word_mode_i && buffer_direction_i && !card_tx_valid_o)
      |=> card_tx_valid_o && card_tx_data_o == $past(mpu_data_i);
  endproperty
  property p_tx_hold;
    card_tx_valid_o && !card_tx_ready_i |=> card_tx_valid_o && $stable(card_tx_data_o);
  endproperty
  a_reset: assert property (p_reset) else $error("reset outputs wrong");
  a_oe: assert property (p_oe) else $error("output enable lag wrong");
  a_stat_word: assert property (p_stat_word) else $error("status read wrong");
  a_stat_hi: assert property (p_stat_hi) else $error("status high byte not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_dir_rd: assert property (p_dir_rd) else $error("portal read in write mode");
  a_tx_push: assert property (p_tx_push) else $error("portal write not pushed");
  a_tx_hold: assert property (p_tx_hold) else $error("stalled head changed");
endmodule // fsbp_portal_properties

// *** testbench/fsbp_portal_bench.sv ***
// Self-checking bench for fsbp_portal with a card-side stream model.
// Assumes the design header on the include path and a 25 MHz core clock.
`timescale 1ns/100ps
module fsbp_portal_bench;
  logic        core_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        mpu_chip_en_n_i = 1'b1;
  logic        mpu_read_en_n_i = 1'b1;
  logic        mpu_write_en_n_i = 1'b1;
  logic        word_mode_i = 1'b1;
  logic        buffer_direction_i = 1'b1;
  logic        sink_en = 1'b0;
  logic [6:0]  mpu_addr_i = 7'h00;
  logic [15:0] mpu_data_i = 16'h0000;
  logic [31:0] cluster_count_i = 32'h0000_0000;
  logic [5:0]  fl = 6'h00;
  logic [7:0]  src_n = 8'h00;
  wire         partition_record_type16_i, master_record_type16_i, partition_record_type12_i;
  wire         master_record_type12_i, partition_record_found_i, master_record_found_i;
  wire  [15:0] mpu_data_o, card_rx_data_i, card_tx_data_o, last_tx;
  wire         mpu_data_oe_o, buffer_ready_o, card_rx_valid_i, card_rx_ready_o;
  wire         card_tx_valid_o, card_tx_ready_i;
  wire  [7:0]  n_tx;
  int          n_fail = 0;
  int          checks_done = 0;
  logic [31:0] cnt [4] = '{32'h0000_0FF4, 32'h0000_0FF5, 32'h0000_FFF4, 32'h0000_FFF5};
  logic [1:0]  e [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
  assign {partition_record_type16_i, master_record_type16_i, partition_record_type12_i,
    master_record_type12_i, partition_record_found_i, master_record_found_i} = fl;
  fsbp_portal i_fsbp_portal (.*);
  fsbp_card_model i_fsbp_card_model (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .src_n_i(src_n), .sink_en_i(sink_en), .rx_valid_o(card_rx_valid_i),
    .rx_data_o(card_rx_data_i), .rx_ready_i(card_rx_ready_o), .tx_valid_i(card_tx_valid_o),
    .tx_data_i(card_tx_data_o), .tx_ready_o(card_tx_ready_i), .last_tx_o(last_tx), .n_tx_o(n_tx));
  task automatic test_done;
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobe held two cycles: one access only, then one idle edge
  task automatic acc(input logic we, input logic [6:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    mpu_chip_en_n_i = 1'b0;
    mpu_read_en_n_i = we;
    mpu_write_en_n_i = !we;
    mpu_addr_i = a;
    mpu_data_i = d;
    repeat (2) @(negedge core_clk_i);
    mpu_chip_en_n_i = 1'b1;
    mpu_read_en_n_i = 1'b1;
    mpu_write_en_n_i = 1'b1;
  endtask
  task automatic wait_on(input int sel);
    int w;
    for (w = 0; w < 200; w++) begin
      if (sel == 0 && card_tx_valid_o === 1'b0) break;
      if (sel == 1 && n_tx === 8'h21) break;
      if (sel == 2 && card_rx_ready_o === 1'b0) break;
      @(negedge core_clk_i);
    end
    if (w == 200) begin
      n_fail++;
      test_done;
    end
  endtask
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (2) @(negedge core_clk_i);
    chk("tx_valid", card_tx_valid_o, 1'b0);
    reset_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      fl = 6'(6'h15 << k);
      cluster_count_i = cnt[k];
      word_mode_i = 1'b1;
      acc(1'b1, 7'h0E, 16'hFFFF);
      acc(1'b0, 7'h0E, 16'h0000);
      chk("status_word", mpu_data_o, {8'h00, e[k], fl});
      acc(1'b0, 7'h01, 16'h0000);
      chk("unmapped", mpu_data_o, 16'h0000);
      word_mode_i = 1'b0;
      acc(1'b0, 7'h1C, 16'h0000);
      chk("status_low", mpu_data_o, {8'h00, e[k], fl});
      acc(1'b0, 7'h1D, 16'h0000);
      chk("status_high", mpu_data_o, 16'h0000);
    end
    word_mode_i = 1'b1;
    for (int k = 0; k < 33; k++) begin
      if (k == 32) chk("ready_full", buffer_ready_o, 1'b0);
      acc(1'b1, 7'(7'h20 + k % 16), 16'(16'hC000 + k));
    end
    sink_en = 1'b1;
    wait_on(0);
    chk("tx_count", n_tx, 8'h20);
    chk("tx_last", last_tx, 16'hC01F);
    word_mode_i = 1'b0;
    acc(1'b1, 7'h40, 16'h0055);
    acc(1'b1, 7'h41, 16'h00AA);
    wait_on(1);
    chk("byte_pair", last_tx, 16'hAA55);
    word_mode_i = 1'b1;
    buffer_direction_i = 1'b0;
    src_n = 8'h22;
    wait_on(2);
    chk("ready_data", buffer_ready_o, 1'b1);
    for (int k = 0; k < 32; k++) begin
      acc(1'b0, 7'(7'h20 + k % 16), 16'h0000);
      chk("rx_word", mpu_data_o, 16'(16'hA000 + k));
    end
    word_mode_i = 1'b0;
    for (int k = 32; k < 34; k++) begin
      acc(1'b0, 7'h40, 16'h0000);
      chk("rx_low", mpu_data_o, 16'(k));
      acc(1'b0, 7'h5F, 16'h0000);
      chk("rx_high", mpu_data_o, 16'h00A0);
    end
    chk("ready_empty", buffer_ready_o, 1'b0);
    acc(1'b1, 7'h41, 16'h00EE);
    chk("dir_write", n_tx, 8'h21);
    buffer_direction_i = 1'b1;
    acc(1'b0, 7'h50, 16'h0000);
    chk("dir_read", mpu_data_o, 16'h0000);
    test_done;
  end
endmodule // fsbp_portal_bench
bind fsbp_portal fsbp_portal_properties i_fsbp_portal_properties (.*);
